/* ots_limit_switch_model.sv */
// Purpose: Limit switch pair and contact model for the supervisor bench
// Assumes: Switch contacts change only between clock edges
// Notes: A terminal reads high while its switch is open, low at 0V
`timescale 1ns/1ps
`default_nettype none

module ots_limit_switch_model (
    // Clock
    input wire logic clock,
    // Commanded switch positions, high means open
    input wire logic fwd_open,
    input wire logic rev_open,
    // Terminals seen by the supervisor
    output logic fwd_limit_terminal,
    output logic rev_limit_terminal
);
    // -----------------------------------------------------------
    // Contact timing
    // -----------------------------------------------------------
    // Contacts settle one edge after the bench moves the switch
    always_ff @(posedge clock) begin
        fwd_limit_terminal <= fwd_open;
        rev_limit_terminal <= rev_open;
    end
endmodule : ots_limit_switch_model

`default_nettype wire

/* ots_pkg.sv */
// Purpose: Shared constants and types for the overtravel/torque supervisor
// Assumes: Torque figures are percent of rated torque, signed 12-bit
// Notes: Register offsets are byte addresses on the plain register port
`default_nettype none

package ots_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned TRQ_W = 12;
    localparam int unsigned SET_W = 10;
    localparam int unsigned SPD_W = 16;
    localparam int unsigned CFG_W = 15;
    localparam int unsigned IRQ_W = 4;
    localparam int unsigned SO_N = 3;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_CFG = 6'h00;
    localparam logic [ADDR_W-1:0] REG_ESTOP = 6'h04;
    localparam logic [ADDR_W-1:0] REG_FWD_LIM = 6'h08;
    localparam logic [ADDR_W-1:0] REG_REV_LIM = 6'h0C;
    localparam logic [ADDR_W-1:0] REG_STATUS = 6'h10;
    localparam logic [ADDR_W-1:0] REG_MONITOR = 6'h14;
    localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 6'h18;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 6'h1C;
    localparam logic [ADDR_W-1:0] REG_TORQUE = 6'h20;

    // ----------------------------------------------------------------
    // Field codes and reset values
    // ----------------------------------------------------------------
    localparam logic [3:0] MAP_UNUSED = 4'h8;
    localparam logic [3:0] MAP_FWD_OPEN = 4'h2;
    localparam logic [3:0] MAP_FWD_INV = 4'hB;
    localparam logic [3:0] MAP_REV_OPEN = 4'h3;
    localparam logic [3:0] MAP_REV_INV = 4'hC;
    localparam logic [1:0] OT_STOP_SOFF = 2'h0;
    localparam logic [1:0] OT_STOP_ZCLAMP = 2'h1;
    localparam logic [1:0] OT_STOP_COAST = 2'h2;
    localparam logic [1:0] FLAG_SEL_NONE = 2'h0;
    localparam logic [SET_W-1:0] TRQ_MAX_SET = 10'h320;
    localparam logic [SET_W-1:0] TRQ_RESET = 10'h320;
    localparam int unsigned IRQ_FWD_OT = 0;
    localparam int unsigned IRQ_REV_OT = 1;
    localparam int unsigned IRQ_TRQ_LIM = 2;
    localparam int unsigned IRQ_STOP_DONE = 3;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_SOFF = 3'b001,
        ST_DECEL = 3'b010,
        ST_ZCLAMP = 3'b011,
        ST_COAST = 3'b100,
        ST_SOFF_DONE = 3'b101
    } ots_stop_t;

    typedef struct packed {
        logic [1:0] limit_flag_output_select;
        logic torque_control;
        logic [1:0] servo_off_stop_mode;
        logic [1:0] overtravel_stop_mode;
        logic [3:0] rev_overtravel_map;
        logic [3:0] fwd_overtravel_map;
    } ots_cfg_t;

    localparam ots_cfg_t CFG_RESET = '{
        limit_flag_output_select: FLAG_SEL_NONE,
        torque_control: 1'b0,
        servo_off_stop_mode: 2'h0,
        overtravel_stop_mode: OT_STOP_SOFF,
        rev_overtravel_map: MAP_UNUSED,
        fwd_overtravel_map: MAP_UNUSED
    };

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } ots_bus_req_t;

    typedef struct packed {
        logic [TRQ_W-1:0] torque;
        logic servo_off_req;
        logic zero_clamp;
        logic coast;
    } ots_drv_out_t;

    typedef struct packed {
        ots_cfg_t cfg;
        logic [SET_W-1:0] estop;
        logic [SET_W-1:0] fwd_lim;
        logic [SET_W-1:0] rev_lim;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        ots_stop_t st;
        logic ot_dir;
        ots_drv_out_t drv;
        logic flag;
        logic [SO_N-1:0] so_n;
        logic [DATA_W-1:0] rdata;
    } ots_state_t;

endpackage : ots_pkg

`default_nettype wire

/* ots_supervisor.sv */
// Purpose: Overtravel stop and internal torque limit supervisor
// Assumes: Inputs synchronous to clock; speed and torque signed values
// Notes: Registers reached over a plain strobe port, read data one cycle on
`timescale 1ns/1ps
`default_nettype none

module ots_supervisor
    import ots_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Register port
    input wire ots_bus_req_t bus_req,
    output logic [DATA_W-1:0] bus_rdata,
    output logic irq,
    // Limit switch terminals, high while open
    input wire logic fwd_limit_terminal,
    input wire logic rev_limit_terminal,
    // Drive torque loop
    input wire logic [TRQ_W-1:0] torque_cmd,
    input wire logic [SPD_W-1:0] motor_speed,
    input wire logic [SET_W-1:0] motor_max_torque,
    output ots_drv_out_t drv_out,
    output logic [1:0] servo_off_stop_mode,
    // Output terminals, so_n low while active; flag and monitor high while active
    input wire logic [SO_N-1:0] other_out_func,
    output logic [SO_N-1:0] so_n,
    output logic torque_limited_flag,
    output logic [SO_N:0] output_signal_monitor
);

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------

    // Effective limit never above motor maximum
    function automatic logic [SET_W-1:0] eff_lim(
        input logic [SET_W-1:0] setting,
        input logic [SET_W-1:0] mx
    );
        return (setting > mx) ? mx : setting;
    endfunction : eff_lim

    // Saturate a written setting to the top of range
    function automatic logic [SET_W-1:0] sat_set(input logic [DATA_W-1:0] v);
        return (v > DATA_W'(TRQ_MAX_SET)) ? TRQ_MAX_SET : v[SET_W-1:0];
    endfunction : sat_set

    // Unsigned magnitude of a signed torque
    function automatic logic [TRQ_W-1:0] mag(input logic [TRQ_W-1:0] v);
        return v[TRQ_W-1] ? TRQ_W'(-$signed(v)) : v;
    endfunction : mag

    // Signed negation of a limit
    function automatic logic [TRQ_W-1:0] neg_lim(input logic [SET_W-1:0] l);
        return TRQ_W'(-$signed({2'h0, l}));
    endfunction : neg_lim

    // Prohibit level from mapping code and terminal level
    function automatic logic prohibit(
        input logic [3:0] map,
        input logic term,
        input logic [3:0] open_code,
        input logic [3:0] inv_code
    );
        if (map == open_code) begin
            return term;
        end else if (map == inv_code) begin
            return ~term;
        end
        return 1'b0;
    endfunction : prohibit

    // ----------------------------------------------------------------
    // State and derived signals
    // ----------------------------------------------------------------
    ots_state_t s_r;
    ots_state_t s_nxt;
    logic fwd_run_prohibit_in;
    logic rev_run_prohibit_in;
    logic fwd_trig;
    logic rev_trig;
    logic dir_pro;
    logic standstill;
    logic spd_pos;
    logic spd_neg;
    logic [SET_W-1:0] fwd_eff;
    logic [SET_W-1:0] rev_eff;
    logic [SET_W-1:0] act_lim;
    logic [SET_W-1:0] stop_trq;
    logic [TRQ_W-1:0] cmd_mag;
    logic [TRQ_W-1:0] run_trq;
    logic run_over;
    logic [IRQ_W-1:0] ev;

    // Run-prohibit mapping
    assign fwd_run_prohibit_in = prohibit(s_r.cfg.fwd_overtravel_map,
        fwd_limit_terminal, MAP_FWD_OPEN, MAP_FWD_INV);
    assign rev_run_prohibit_in = prohibit(s_r.cfg.rev_overtravel_map,
        rev_limit_terminal, MAP_REV_OPEN, MAP_REV_INV);

    // Motion and trigger detection
    assign spd_pos = $signed(motor_speed) > $signed(16'h0000);
    assign spd_neg = motor_speed[SPD_W-1];
    assign fwd_trig = fwd_run_prohibit_in &&
        (spd_pos || ($signed(torque_cmd) > $signed(12'h000)));
    assign rev_trig = rev_run_prohibit_in && (spd_neg || torque_cmd[TRQ_W-1]);
    assign dir_pro = s_r.ot_dir ? fwd_run_prohibit_in : rev_run_prohibit_in;
    assign standstill = s_r.ot_dir ? !spd_pos : !spd_neg;

    // Limit selection and saturation
    assign fwd_eff = eff_lim(s_r.fwd_lim, motor_max_torque);
    assign rev_eff = eff_lim(s_r.rev_lim, motor_max_torque);
    assign stop_trq = eff_lim(s_r.estop, motor_max_torque);
    assign act_lim = torque_cmd[TRQ_W-1] ? rev_eff : fwd_eff;
    assign cmd_mag = mag(torque_cmd);
    assign run_over = cmd_mag > {2'h0, act_lim};
    assign run_trq = !run_over ? torque_cmd :
        (torque_cmd[TRQ_W-1] ? neg_lim(act_lim) : {2'h0, act_lim});

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        ev = '0;
        // Overtravel stop sequencing
        unique case (s_r.st)
            ST_RUN: begin
                if (fwd_trig || rev_trig) begin
                    s_nxt.ot_dir = fwd_trig;
                    ev[IRQ_FWD_OT] = fwd_trig;
                    ev[IRQ_REV_OT] = !fwd_trig;
                    if (s_r.cfg.overtravel_stop_mode == OT_STOP_SOFF) begin
                        s_nxt.st = ST_SOFF;
                    end else begin
                        s_nxt.st = ST_DECEL;
                    end
                end
            end
            ST_SOFF: begin
                if (!dir_pro) begin
                    s_nxt.st = ST_RUN;
                end else if (standstill) begin
                    ev[IRQ_STOP_DONE] = 1'b1;
                    s_nxt.st = s_r.cfg.torque_control ? ST_COAST : ST_SOFF_DONE;
                end
            end
            ST_DECEL: begin
                if (!dir_pro) begin
                    s_nxt.st = ST_RUN;
                end else if (standstill) begin
                    ev[IRQ_STOP_DONE] = 1'b1;
                    if (s_r.cfg.torque_control ||
                        s_r.cfg.overtravel_stop_mode != OT_STOP_ZCLAMP) begin
                        s_nxt.st = ST_COAST;
                    end else begin
                        s_nxt.st = ST_ZCLAMP;
                    end
                end
            end
            ST_ZCLAMP, ST_COAST, ST_SOFF_DONE: begin
                if (!dir_pro) begin
                    s_nxt.st = ST_RUN;
                end
            end
            default: begin
                s_nxt.st = ST_RUN;
            end
        endcase
        // Torque reference and stop outputs
        s_nxt.flag = 1'b0;
        s_nxt.drv.torque = '0;
        unique case (s_nxt.st)
            ST_RUN: begin
                s_nxt.drv.torque = run_trq;
                s_nxt.flag = run_over;
            end
            ST_DECEL: begin
                s_nxt.drv.torque = s_nxt.ot_dir ? neg_lim(stop_trq) :
                    {2'h0, stop_trq};
            end
            default: begin
                s_nxt.drv.torque = '0;
            end
        endcase
        s_nxt.drv.servo_off_req = (s_nxt.st == ST_SOFF) ||
            (s_nxt.st == ST_SOFF_DONE);
        s_nxt.drv.zero_clamp = s_nxt.st == ST_ZCLAMP;
        s_nxt.drv.coast = s_nxt.st == ST_COAST;
        ev[IRQ_TRQ_LIM] = s_nxt.flag && !s_r.flag;
        // Output terminal routing, active low
        for (int i = 0; i < SO_N; i++) begin
            s_nxt.so_n[i] = !(other_out_func[i] ||
                (s_r.cfg.limit_flag_output_select == 2'(i + 1) &&
                s_nxt.flag));
        end
        // Register writes
        if (bus_req.wr) begin
            unique case (bus_req.addr)
                REG_CFG: s_nxt.cfg = ots_cfg_t'(bus_req.wdata[CFG_W-1:0]);
                REG_ESTOP: s_nxt.estop = sat_set(bus_req.wdata);
                REG_FWD_LIM: s_nxt.fwd_lim = sat_set(bus_req.wdata);
                REG_REV_LIM: s_nxt.rev_lim = sat_set(bus_req.wdata);
                REG_IRQ_MASK: s_nxt.irq_mask = bus_req.wdata[IRQ_W-1:0];
                default: begin
                end
            endcase
        end
        // Sticky status, read clears, new event wins
        s_nxt.irq_stat = ((bus_req.rd && bus_req.addr == REG_IRQ_STAT) ?
            '0 : s_r.irq_stat) | ev;
        // Read data, valid only in the cycle after the strobe
        s_nxt.rdata = '0;
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                REG_CFG: s_nxt.rdata = DATA_W'(s_r.cfg);
                REG_ESTOP: s_nxt.rdata = DATA_W'(s_r.estop);
                REG_FWD_LIM: s_nxt.rdata = DATA_W'(s_r.fwd_lim);
                REG_REV_LIM: s_nxt.rdata = DATA_W'(s_r.rev_lim);
                REG_STATUS: s_nxt.rdata = DATA_W'({s_r.st, s_r.ot_dir,
                    rev_run_prohibit_in, fwd_run_prohibit_in, s_r.flag});
                REG_MONITOR: s_nxt.rdata = DATA_W'({s_r.flag, ~s_r.so_n});
                REG_IRQ_STAT: s_nxt.rdata = DATA_W'(s_r.irq_stat);
                REG_IRQ_MASK: s_nxt.rdata = DATA_W'(s_r.irq_mask);
                REG_TORQUE: s_nxt.rdata = DATA_W'(s_r.drv.torque);
                default: s_nxt.rdata = '0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_r <= '0;
            s_r.cfg <= CFG_RESET;
            s_r.estop <= TRQ_RESET;
            s_r.fwd_lim <= TRQ_RESET;
            s_r.rev_lim <= TRQ_RESET;
            s_r.st <= ST_RUN;
            s_r.so_n <= '1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs
    assign bus_rdata = s_r.rdata;
    assign irq = |(s_r.irq_stat & s_r.irq_mask);
    assign drv_out = s_r.drv;
    assign servo_off_stop_mode = s_r.cfg.servo_off_stop_mode;
    assign so_n = s_r.so_n;
    assign torque_limited_flag = s_r.flag;
    assign output_signal_monitor = {s_r.flag, ~s_r.so_n};

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    sequence seq_ot_held;
        s_r.st == ST_DECEL && dir_pro && standstill;
    endsequence

    sequence seq_soff_trig;
        s_r.st == ST_RUN && (fwd_trig || rev_trig) &&
            s_r.cfg.overtravel_stop_mode == OT_STOP_SOFF;
    endsequence

    a_fwd_map_ignore: assert property (
        s_r.cfg.fwd_overtravel_map == MAP_UNUSED |-> !fwd_run_prohibit_in)
        else $error("forward limit not ignored");
    a_fwd_map_open: assert property (
        s_r.cfg.fwd_overtravel_map == MAP_FWD_OPEN |->
            fwd_run_prohibit_in == fwd_limit_terminal)
        else $error("forward open mapping wrong");
    a_fwd_map_inv: assert property (
        s_r.cfg.fwd_overtravel_map == MAP_FWD_INV |->
            fwd_run_prohibit_in != fwd_limit_terminal)
        else $error("forward inverted mapping wrong");
    a_rev_map_ignore: assert property (
        s_r.cfg.rev_overtravel_map == MAP_UNUSED |-> !rev_run_prohibit_in)
        else $error("reverse limit not ignored");
    a_rev_map_open: assert property (
        s_r.cfg.rev_overtravel_map == MAP_REV_OPEN |->
            rev_run_prohibit_in == rev_limit_terminal)
        else $error("reverse open mapping wrong");
    a_rev_map_inv: assert property (
        s_r.cfg.rev_overtravel_map == MAP_REV_INV |->
            rev_run_prohibit_in != rev_limit_terminal)
        else $error("reverse inverted mapping wrong");
    a_soff_entry: assert property (
        seq_soff_trig |=> s_r.st == ST_SOFF && drv_out.servo_off_req)
        else $error("servo-off stop not entered");
    a_decel_zclamp: assert property (
        seq_ot_held ##0 (s_r.cfg.overtravel_stop_mode == OT_STOP_ZCLAMP &&
            !s_r.cfg.torque_control) |=> drv_out.zero_clamp)
        else $error("zero clamp not entered after decel");
    a_decel_coast: assert property (
        seq_ot_held ##0 (s_r.cfg.overtravel_stop_mode == OT_STOP_COAST)
            |=> drv_out.coast && drv_out.torque == '0)
        else $error("coast not entered after decel");
    a_trqctl_coast: assert property (
        seq_ot_held ##0 s_r.cfg.torque_control |=> s_r.st == ST_COAST)
        else $error("torque control stop did not coast");
    a_decel_torque: assert property (
        s_r.st == ST_DECEL |-> mag(drv_out.torque) ==
            {2'h0, eff_lim($past(s_r.estop), $past(motor_max_torque))})
        else $error("decel torque not stop torque");
    a_torque_clamp: assert property (
        s_r.st == ST_RUN && $past(s_r.st) == ST_RUN |->
            mag(drv_out.torque) <= {2'h0, $past(act_lim)})
        else $error("torque above active limit");
    a_motor_max: assert property (
        s_r.st == ST_RUN && $past(s_r.st) == ST_RUN |->
            mag(drv_out.torque) <= {2'h0, $past(motor_max_torque)})
        else $error("torque above motor maximum");
    a_flag_set: assert property (
        s_r.st == ST_RUN && (fwd_trig || rev_trig) == 1'b0 && run_over
            |=> torque_limited_flag ##1 1'b1)
        else $error("limited flag not raised");
    a_flag_route: assert property (
        1'b1 |=> so_n[0] == !($past(other_out_func[0]) ||
            ($past(s_r.cfg.limit_flag_output_select) == 2'h1 &&
            torque_limited_flag)))
        else $error("terminal routing wrong");
    a_sign_follow: assert property (
        s_r.st == ST_RUN && !fwd_trig && !rev_trig &&
            !torque_cmd[TRQ_W-1] |=> !drv_out.torque[TRQ_W-1])
        else $error("positive command gave negative torque");
    a_soff_coast: assert property (
        s_r.st == ST_SOFF && dir_pro && standstill &&
            s_r.cfg.torque_control |=> drv_out.coast)
        else $error("servo-off stop under torque control did not coast");
    a_flag_clear: assert property (
        s_r.st == ST_RUN && !fwd_trig && !rev_trig && !run_over
            |=> !torque_limited_flag)
        else $error("limited flag raised without excess torque");
    a_route_none: assert property (
        s_r.cfg.limit_flag_output_select == FLAG_SEL_NONE
            |=> so_n == ~$past(other_out_func))
        else $error("limited flag reached an unselected terminal");
    a_decel_sense: assert property (
        s_r.st == ST_DECEL && drv_out.torque != '0 |->
            drv_out.torque[TRQ_W-1] == s_r.ot_dir)
        else $error("stop torque does not oppose motion");
    a_stop_event: assert property (
        seq_ot_held |=> s_r.irq_stat[IRQ_STOP_DONE])
        else $error("stop completion not recorded");

endmodule : ots_supervisor

`default_nettype wire

/* ots_supervisor_tb.sv */
// Purpose: Self-checking bench for the overtravel and torque supervisor
// Assumes: Register reads answer in the cycle after the read strobe
// Notes: Motor maximum torque held at 300 percent throughout
`timescale 1ns/1ps
`default_nettype none

module ots_supervisor_tb;
    import ots_pkg::*;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    ots_bus_req_t bus_req = '0;
    logic [DATA_W-1:0] bus_rdata;
    logic irq, fwd_t, rev_t, fwd_open = 1'b0, rev_open = 1'b0;
    logic [TRQ_W-1:0] torque_cmd = '0;
    logic [SPD_W-1:0] motor_speed = '0;
    logic [SET_W-1:0] motor_max_torque = 10'h12C;
    ots_drv_out_t drv_out;
    logic [1:0] soff_mode;
    logic [SO_N-1:0] other_out_func = '0, so_n;
    logic flag;
    logic [SO_N:0] mon;
    int mismatches = 0;
    int check_count = 0;

    ots_limit_switch_model ots_limit_switch_model_i (.clock(clock),
        .fwd_open(fwd_open), .rev_open(rev_open),
        .fwd_limit_terminal(fwd_t), .rev_limit_terminal(rev_t));
    ots_supervisor ots_supervisor_i (.clock(clock), .resetn(resetn),
        .bus_req(bus_req), .bus_rdata(bus_rdata), .irq(irq),
        .fwd_limit_terminal(fwd_t), .rev_limit_terminal(rev_t),
        .torque_cmd(torque_cmd), .motor_speed(motor_speed),
        .motor_max_torque(motor_max_torque), .drv_out(drv_out),
        .servo_off_stop_mode(soff_mode), .other_out_func(other_out_func),
        .so_n(so_n), .torque_limited_flag(flag),
        .output_signal_monitor(mon));

    initial begin
        forever #5 clock = ~clock;
    end

    // -----------------------------------------------------------
    // Shared tasks
    // -----------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : wait_cyc

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus_req <= '0;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus_req <= '0;
        #1;
        d = bus_rdata;
    endtask : rd

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk(d, e);
    endtask : rd_chk

    // Runs a stop: sets switches and mode, moves, then reaches standstill
    task automatic run_stop(input logic [31:0] cfg, input logic fo,
                            input logic ro, input logic [15:0] spd,
                            input logic [11:0] trq, input logic [31:0] stat,
                            input logic [2:0] end_flags);
        @(posedge clock);
        fwd_open <= fo;
        rev_open <= ro;
        wr(REG_CFG, cfg);
        @(posedge clock);
        motor_speed <= spd;
        wait_cyc(3);
        chk(drv_out.torque, trq);
        rd_chk(REG_STATUS, stat);
        @(posedge clock);
        motor_speed <= '0;
        wait_cyc(3);
        chk({drv_out.servo_off_req, drv_out.zero_clamp, drv_out.coast},
            end_flags);
        wr(REG_CFG, 32'h088);
    endtask : run_stop

    task automatic results();
        if (mismatches == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    // -----------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------
    task automatic sc_reset();
        rd_chk(REG_CFG, 32'(CFG_RESET));
        rd_chk(REG_ESTOP, 32'h320);
        rd_chk(REG_FWD_LIM, 32'h320);
        rd_chk(REG_REV_LIM, 32'h320);
        rd_chk(6'h3C, 32'h0);
        chk(so_n, 3'h7);
    endtask : sc_reset

    task automatic sc_ignored();
        @(posedge clock);
        fwd_open <= 1'b1;
        rev_open <= 1'b1;
        motor_speed <= 16'h0010;
        wait_cyc(3);
        chk(drv_out, '0);
        rd_chk(REG_STATUS, 32'h0);
    endtask : sc_ignored

    task automatic sc_stops();
        run_stop(32'h182, 1'b1, 1'b0, 16'h0010, 12'hED4, 32'h2A,
            3'h2);
        wr(REG_IRQ_MASK, 32'h8);
        wait_cyc(1);
        chk(irq, 1'b1);
        rd_chk(REG_IRQ_STAT, 32'h9);
        wait_cyc(1);
        chk(irq, 1'b0);
        run_stop(32'h28B, 1'b0, 1'b0, 16'h0010, 12'hED4, 32'h2A,
            3'h1);
        run_stop(32'h038, 1'b0, 1'b1, 16'hFFF0, 12'h000, 32'h14,
            3'h4);
        run_stop(32'h11C8, 1'b0, 1'b0, 16'hFFF0, 12'h12C, 32'h24,
            3'h1);
    endtask : sc_stops

    task automatic sc_limits();
        wr(REG_REV_LIM, 32'h064);
        wr(REG_CFG, 32'h4888);
        @(posedge clock);
        torque_cmd <= 12'hF38;
        other_out_func <= 3'h1;
        wait_cyc(3);
        chk(drv_out.torque, 12'hF9C);
        chk(flag, 1'b1);
        chk(so_n, 3'h4);
        chk(mon, 4'hB);
        chk(soff_mode, 2'h2);
        rd_chk(REG_MONITOR, 32'hB);
        rd_chk(REG_IRQ_STAT, 32'hF);
        rd_chk(REG_TORQUE, 32'hF9C);
        @(posedge clock);
        torque_cmd <= 12'h0C8;
        wait_cyc(3);
        chk({flag, drv_out.torque}, 13'h00C8);
        @(posedge clock);
        torque_cmd <= 12'h190;
        wait_cyc(3);
        chk({flag, drv_out.torque}, 13'h112C);
    endtask : sc_limits

    initial begin
        #200us;
        mismatches++;
        results();
    end

    initial begin
        wait_cyc(5);
        resetn <= 1'b1;
        sc_reset();
        sc_ignored();
        sc_stops();
        sc_limits();
        results();
    end
endmodule : ots_supervisor_tb

`default_nettype wire
